// ===== logic/iodec_decoder.sv
// instruction word decoder: splits 12-bit words into opcode and operand fields
// assumes: instruction word comes from program memory on the same clock;
// SYS_CLK is the oscillator, one instruction cycle is four enabled clocks;
// SYS_RST and CLK_EN are same-clock signals, so no synchroniser sits on them;
// the execute stage reads the fields while ISSUE_STB is high or any time after
`include "iodec_defs.svh"

`default_nettype none

module iodec_decoder
    import iodec_pkg::*;
#(
    parameter int unsigned OSC_PER_CYC = `IODEC_OSC_PER_CYC
)
(
    // clock, reset, enable
    input  wire logic                       SYS_CLK,
    input  wire logic                       SYS_RST,
    input  wire logic                       CLK_EN,
    // instruction word from program memory
    input  wire logic [`IODEC_WORD_W-1:0]   INSTR_WORD,
    // decoded fields
    output var  logic                       ISSUE_STB,
    output var  logic [1:0]                 INSTR_CLASS,
    output var  logic [5:0]                 OPCODE,
    output var  logic [`IODEC_FILE_W-1:0]   FILE_SEL,
    output var  logic                       DEST_FILE,
    output var  logic [`IODEC_BIT_W-1:0]    BIT_SEL,
    output var  logic [`IODEC_LIT_W-1:0]    LITERAL,
    output var  logic                       LIT_WIDE
);

    // ------------------------------------------------------------
    // class decode
    // ------------------------------------------------------------
    // top bits only; lower operand bits are passed in but never examined
    function automatic iodec_class_t classify(input logic [`IODEC_WORD_W-1:0] w);
        if (w[11:10] == `IODEC_BYTE_GROUP)
        begin
            classify = IODEC_CLASS_BYTE;
        end
        else if (w[11:10] == `IODEC_BIT_GROUP)
        begin
            classify = IODEC_CLASS_BIT;
        end
        else if (w[11:9] == `IODEC_JUMP_OP)
        begin
            classify = IODEC_CLASS_JUMP;
        end
        else
        begin
            classify = IODEC_CLASS_LIT;
        end
    endfunction : classify

    // ------------------------------------------------------------
    // instruction cycle pacing
    // ------------------------------------------------------------
    // the count stops while CLK_EN is low, so a stalled core never loses a fetch slot;
    // words offered on the other phases are simply ignored
    localparam int unsigned PH_W = (OSC_PER_CYC > 1) ? $clog2(OSC_PER_CYC) : 1;
    localparam logic [PH_W-1:0] PH_LAST = PH_W'(OSC_PER_CYC - 1);

    logic [PH_W-1:0] phase_q;
    logic [PH_W-1:0] phase_d;
    logic            issue_now;

    always_comb
    begin
        issue_now = (phase_q == PH_LAST);
        phase_d   = issue_now ? '0 : phase_q + PH_W'(1);
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
            phase_q <= '0;
        else if (CLK_EN)
            phase_q <= phase_d;
    end

    // ------------------------------------------------------------
    // field extraction
    // ------------------------------------------------------------
    logic                     issue_q;
    logic                     issue_d;
    logic [1:0]               class_q;
    logic [1:0]               class_d;
    logic [5:0]               opcode_q;
    logic [5:0]               opcode_d;
    logic [`IODEC_FILE_W-1:0] file_q;
    logic [`IODEC_FILE_W-1:0] file_d;
    logic                     dest_q;
    logic                     dest_d;
    logic [`IODEC_BIT_W-1:0]  bit_q;
    logic [`IODEC_BIT_W-1:0]  bit_d;
    logic [`IODEC_LIT_W-1:0]  lit_q;
    logic [`IODEC_LIT_W-1:0]  lit_d;
    logic                     wide_q;
    logic                     wide_d;
    iodec_class_t             cls;

    // ------------------------------------------------------------
    // next field values
    // ------------------------------------------------------------
    // unused fields are forced to zero so don't-care bits never leak out;
    // a few gates more, but the execute stage may read any field blindly
    always_comb
    begin
        cls      = classify(INSTR_WORD);
        issue_d  = issue_now;
        class_d  = issue_now ? cls : class_q;
        opcode_d = opcode_q;
        file_d   = file_q;
        dest_d   = dest_q;
        bit_d    = bit_q;
        lit_d    = lit_q;
        wide_d   = wide_q;
        if (issue_now)
        begin
            opcode_d = '0;
            file_d   = '0;
            dest_d   = 1'h0;
            bit_d    = '0;
            lit_d    = '0;
            wide_d   = 1'h0;
            case (cls)
                IODEC_CLASS_BYTE:
                begin
                    opcode_d = INSTR_WORD[11:`IODEC_BYTE_OP_LSB];
                    dest_d   = INSTR_WORD[`IODEC_DEST_POS];
                    file_d   = INSTR_WORD[4:`IODEC_FILE_LSB];
                end
                IODEC_CLASS_BIT:
                begin
                    opcode_d = {2'h0, INSTR_WORD[11:`IODEC_LIT_OP_LSB]};
                    bit_d    = INSTR_WORD[7:`IODEC_BIT_LSB];
                    file_d   = INSTR_WORD[4:`IODEC_FILE_LSB];
                end
                IODEC_CLASS_JUMP:
                begin
                    opcode_d = {3'h0, INSTR_WORD[11:`IODEC_JUMP_OP_LSB]};
                    lit_d    = INSTR_WORD[8:0];
                    wide_d   = 1'b1;
                end
                IODEC_CLASS_LIT:
                begin
                    opcode_d = {2'h0, INSTR_WORD[11:`IODEC_LIT_OP_LSB]};
                    lit_d    = {1'b0, INSTR_WORD[7:0]};
                end
                default:
                begin
                    // no code reaches here; listed so a stray class stays inert
                    opcode_d = '0;
                    file_d   = '0;
                    dest_d   = 1'h0;
                    bit_d    = '0;
                    lit_d    = '0;
                    wide_d   = 1'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // field registers
    // ------------------------------------------------------------
    // reset wins over CLK_EN, so a single edge always clears the outputs
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            issue_q  <= 1'b0;
            class_q  <= 2'h0;
            opcode_q <= 6'h0;
            file_q   <= '0;
            dest_q   <= 1'b0;
            bit_q    <= '0;
            lit_q    <= '0;
            wide_q   <= 1'b0;
        end
        else if (CLK_EN)
        begin
            issue_q  <= issue_d;
            class_q  <= class_d;
            opcode_q <= opcode_d;
            file_q   <= file_d;
            dest_q   <= dest_d;
            bit_q    <= bit_d;
            lit_q    <= lit_d;
            wide_q   <= wide_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign ISSUE_STB   = issue_q;
    assign INSTR_CLASS = class_q;
    assign OPCODE      = opcode_q;
    assign FILE_SEL    = file_q;
    assign DEST_FILE   = dest_q;
    assign BIT_SEL     = bit_q;
    assign LITERAL     = lit_q;
    assign LIT_WIDE    = wide_q;

endmodule : iodec_decoder

`default_nettype wire

// ===== include/iodec_defs.svh
// field positions, widths and timing counts of the instruction word decoder
// assumes: included by the decoder package and the design file by bare name
`ifndef IODEC_DEFS_SVH
`define IODEC_DEFS_SVH

`define IODEC_WORD_W        12
`define IODEC_FILE_W        5
`define IODEC_BIT_W         3
`define IODEC_LIT_W         9
`define IODEC_FILE_LSB      0
`define IODEC_DEST_POS      5
`define IODEC_BIT_LSB       5
`define IODEC_BYTE_OP_LSB   6
`define IODEC_LIT_OP_LSB    8
`define IODEC_JUMP_OP_LSB   9
`define IODEC_OSC_PER_CYC   4
`define IODEC_JUMP_OP       3'h5
`define IODEC_BIT_GROUP     2'h1
`define IODEC_BYTE_GROUP    2'h0

`endif

// ===== include/iodec_pkg.sv
// types shared by the instruction word decoder
// assumes: iodec_defs.svh on the include path
`include "iodec_defs.svh"

package iodec_pkg;

    typedef enum logic [1:0]
    {
        IODEC_CLASS_BYTE = 2'b00,
        IODEC_CLASS_BIT  = 2'b01,
        IODEC_CLASS_LIT  = 2'b10,
        IODEC_CLASS_JUMP = 2'b11
    } iodec_class_t;

    typedef enum logic [1:0]
    {
        IODEC_PH_Q1 = 2'b00,
        IODEC_PH_Q2 = 2'b01,
        IODEC_PH_Q3 = 2'b10,
        IODEC_PH_Q4 = 2'b11
    } iodec_phase_t;

endpackage : iodec_pkg

// ===== bench/iodec_prog_mem.sv
// program memory model feeding instruction words to the decoder
// assumes: decoder samples on every fourth enabled clock after reset
`default_nettype none
module iodec_prog_mem
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic [11:0] word,
    output var  logic [11:0] instr_word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] slot_q;
    always_ff @(posedge clk) slot_q <= rst ? 2'h0 : slot_q + 2'(clk_en);
    // off the fetch slot the bus carries the inverse, so a wrong sample shows
    assign instr_word = (slot_q == 2'h3) ? word : ~word;
endmodule : iodec_prog_mem
`default_nettype wire

// ===== bench/iodec_monitor.sv
// concurrent checks on the decoder ports
// assumes: bound to iodec_decoder, one clock domain
`default_nettype none
module iodec_monitor
    import iodec_pkg::*;
#(
    parameter int unsigned OSC_PER_CYC = 4
)
(
    input wire logic        SYS_CLK,
    input wire logic        SYS_RST,
    input wire logic        CLK_EN,
    input wire logic [11:0] INSTR_WORD,
    input wire logic        ISSUE_STB,
    input wire logic [1:0]  INSTR_CLASS,
    input wire logic [5:0]  OPCODE,
    input wire logic [4:0]  FILE_SEL,
    input wire logic        DEST_FILE,
    input wire logic [2:0]  BIT_SEL,
    input wire logic [8:0]  LITERAL,
    input wire logic        LIT_WIDE
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] w_q;
    always_ff @(posedge SYS_CLK) if (CLK_EN) w_q <= INSTR_WORD;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    a_class_map: assert property ($rose(ISSUE_STB) |->
        INSTR_CLASS == (w_q[11:10] == 2'h0 ? 2'h0 : w_q[11:10] == 2'h1 ? 2'h1 :
        w_q[11:9] == 3'h5 ? 2'h3 : 2'h2)) else $error("class wrong");
    a_byte_fields: assert property ($rose(ISSUE_STB) && w_q[11:10] == 2'h0 |->
        OPCODE == w_q[11:6] && FILE_SEL == w_q[4:0] && DEST_FILE == w_q[5] && BIT_SEL == 3'h0)
        else $error("byte fields");
    a_bit_fields: assert property ($rose(ISSUE_STB) && w_q[11:10] == 2'h1 |->
        OPCODE[3:0] == w_q[11:8] && FILE_SEL == w_q[4:0] && BIT_SEL == w_q[7:5] && !DEST_FILE)
        else $error("bit fields");
    a_lit_fields: assert property ($rose(ISSUE_STB) && w_q[11] && w_q[11:9] != 3'h5 |->
        LITERAL == {1'b0, w_q[7:0]} && OPCODE == {2'h0, w_q[11:8]} && !LIT_WIDE)
        else $error("literal");
    a_jump_fields: assert property ($rose(ISSUE_STB) && w_q[11:9] == 3'h5 |->
        LITERAL == w_q[8:0] && OPCODE == 6'h05 && LIT_WIDE) else $error("jump fields");
    a_strobe_pulse: assert property (ISSUE_STB && CLK_EN |=> !ISSUE_STB [*3])
        else $error("strobe too long");
    a_fields_hold: assert property (!ISSUE_STB && !$past(SYS_RST) |->
        $stable({INSTR_CLASS, OPCODE, FILE_SEL, DEST_FILE, BIT_SEL, LITERAL, LIT_WIDE}))
        else $error("fields moved");
    a_issue_pace: assert property (ISSUE_STB && CLK_EN ##1 CLK_EN [*3] |=> ISSUE_STB)
        else $error("issue late");
endmodule : iodec_monitor
bind iodec_decoder iodec_monitor #(.OSC_PER_CYC(OSC_PER_CYC)) u_mon (.SYS_CLK(SYS_CLK),
    .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .INSTR_WORD(INSTR_WORD), .ISSUE_STB(ISSUE_STB),
    .INSTR_CLASS(INSTR_CLASS), .OPCODE(OPCODE), .FILE_SEL(FILE_SEL), .DEST_FILE(DEST_FILE),
    .BIT_SEL(BIT_SEL), .LITERAL(LITERAL), .LIT_WIDE(LIT_WIDE));
`default_nettype wire

// ===== bench/instruction_operand_decoder_tb.sv
// self-checking bench for the instruction word decoder
// assumes: program memory model and monitor compiled before this file
`default_nettype none
module instruction_operand_decoder_tb;
    import iodec_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, sys_rst, clk_en, issue_stb, dest_file, lit_wide;
    logic [11:0] word, instr_word;
    logic [1:0]  instr_class;
    logic [5:0]  opcode;
    logic [4:0]  file_sel;
    logic [2:0]  bit_sel;
    logic [8:0]  literal;
    logic [26:0] fields;
    int          error_cnt = 0;
    int          checked = 0;
    logic [11:0] byte_words [4] = '{12'h13F, 12'h100, 12'h3E0, 12'h01F};
    logic [11:0] bit_words  [3] = '{12'h4FF, 12'h700, 12'h5A5};
    logic [11:0] lit_words  [6] = '{12'hD35, 12'h8FF, 12'hF00, 12'hA00, 12'hBFF, 12'h9A5};
    iodec_prog_mem u_mem (.clk(sys_clk), .rst(sys_rst), .clk_en(clk_en), .word(word),
        .instr_word(instr_word));
    iodec_decoder DUT (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .CLK_EN(clk_en),
        .INSTR_WORD(instr_word), .ISSUE_STB(issue_stb), .INSTR_CLASS(instr_class),
        .OPCODE(opcode), .FILE_SEL(file_sel), .DEST_FILE(dest_file), .BIT_SEL(bit_sel),
        .LITERAL(literal), .LIT_WIDE(lit_wide));
    assign fields = {instr_class, opcode, file_sel, dest_file, bit_sel, literal, lit_wide};
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic chk(input string name, input logic [26:0] exp, input logic [26:0] got);
        checked++;
        if (got !== exp) error_cnt++;
        if (got !== exp) $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    endtask : chk
    function automatic logic [26:0] expect_of(input logic [11:0] w);
        if (w[11:10] == 2'h0) return {2'h0, w[11:6], w[4:0], w[5], 3'h0, 9'h000, 1'b0};
        if (w[11:10] == 2'h1) return {2'h1, 2'h0, w[11:8], w[4:0], 1'b0, w[7:5], 9'h000, 1'b0};
        if (w[11:9] == 3'h5) return {2'h3, 6'h05, 5'h00, 1'b0, 3'h0, w[8:0], 1'b1};
        return {2'h2, 2'h0, w[11:8], 5'h00, 1'b0, 3'h0, 1'b0, w[7:0], 1'b0};
    endfunction : expect_of
    // one word per instruction cycle, four enabled clocks apart
    task automatic run_word(input logic [11:0] w);
        int n;
        word = w;
        n = 0;
        do @(negedge sys_clk); while (issue_stb !== 1'b1 && ++n < 12);
        chk("issue spacing", 27'(4), 27'(n + 1));
        chk("decoded fields", expect_of(w), fields);
    endtask : run_word
    task automatic t_byte;
        foreach (byte_words[i]) run_word(byte_words[i]);
        $display("byte test done");
    endtask : t_byte
    task automatic t_bit;
        foreach (bit_words[i]) run_word(bit_words[i]);
        $display("bit test done");
    endtask : t_bit
    task automatic t_lit;
        foreach (lit_words[i]) run_word(lit_words[i]);
        $display("literal test done");
    endtask : t_lit
    // enable low between issues: nothing moves, pacing resumes where it stopped
    task automatic t_freeze;
        logic [26:0] held;
        int          n;
        held = fields;
        word = 12'h2A7;
        @(negedge sys_clk);
        clk_en = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk("frozen strobe", 27'(0), 27'(issue_stb));
        chk("frozen fields", held, fields);
        clk_en = 1'b1;
        n = 0;
        do @(negedge sys_clk); while (issue_stb !== 1'b1 && ++n < 12);
        chk("resumed spacing", 27'(3), 27'(n + 1));
        chk("resumed fields", expect_of(12'h2A7), fields);
        $display("freeze test done");
    endtask : t_freeze
    // reset in mid-run clears every output and restarts the cycle count
    task automatic t_reset;
        sys_rst = 1'b1;
        @(negedge sys_clk);
        chk("reset strobe", 27'(0), 27'(issue_stb));
        chk("reset fields", 27'(0), fields);
        sys_rst = 1'b0;
        run_word(12'h9C3);
        $display("reset test done");
    endtask : t_reset
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    initial
    begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        word = 12'h000;
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
        t_byte();
        t_bit();
        t_lit();
        t_freeze();
        t_reset();
        final_report();
    end
    // whole run needs about 72 cycles
    initial
    begin
        #(200 * 50);
        error_cnt++;
        final_report();
    end
endmodule : instruction_operand_decoder_tb
`default_nettype wire
